// ==== hdl/swrc_pkg.sv ====
// constants and types shared by the sleep, wake and reset block
//
// What this block does
// - setting the sleep bit of the power register puts the device to sleep
// - general-purpose pins hold their direction and configuration while asleep
// - external memory address outputs are driven low while asleep
// - sleep turns off crystal drive, pll, booster and usb transceivers
// - the processor is suspended and runs nothing while asleep
// - any enabled source wakes the device: resume, bus power, id, port reads, external_irq_line_zero
// - a port read used to wake returns dummy data which the reader drops
// - after a wake the pll restarts and code resumes within the settle time
// - a usb resume wake raises the host port interrupt output
// - a pin reset returns every register to its power-on default
// - after reset and settling, fetch starts at ff00 then jumps to e000
// - for the test window after rom start some gpios are driven as outputs
// - a usb bus reset leaves every register of this block unchanged
// - processor space is 64k bytes, control registers c000-c0ff, rom e000-ffff
// - the speed register slows only the processor, never peripheral timing
// - flags bit 4 reads the global interrupt enable state
// - flags bit 3 copies the top bit of the last arithmetic result
// - flags bit 2 shows signed overflow of an add or subtract
// - flags bit 1 shows carry of an add or borrow of a subtract
// - flags bit 0 shows a zero result; bits 15 to 5 read zero
// - each writable wake enable bit gates its own wake source, except the otg bit, which gates both bus power and id
package swrc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_FLAGS = 16'hc000;
  localparam logic [15:0] IDX_BANK = 16'hc002;
  localparam logic [15:0] IDX_REV = 16'hc004;
  localparam logic [15:0] IDX_SPEED = 16'hc008;
  localparam logic [15:0] IDX_POWER = 16'hc00a;
  localparam logic [15:0] IDX_IRQEN = 16'hc00e;
  localparam logic [15:0] IDX_BRK = 16'hc014;
  localparam logic [15:0] IDX_DIAG = 16'hc03c;
  // reset values and writable masks
  localparam logic [15:0] RST_BANK = 16'h0100;
  localparam logic [15:0] BANK_WMASK = 16'hfff0;
  localparam logic [15:0] RST_SPEED = 16'h000f;
  localparam logic [15:0] SPEED_WMASK = 16'h000f;
  localparam logic [15:0] POWER_WMASK = 16'h5b93;
  // power register fields
  localparam int PWR_HALT = 0;
  localparam int PWR_SLEEP = 1;
  localparam int PWR_BOOST_OK = 2;
  localparam int PWR_GPI = 4;
  localparam int PWR_HPI = 7;
  localparam int PWR_SPI = 8;
  localparam int PWR_HSS = 9;
  localparam int PWR_OTG = 11;
  localparam int PWR_HD1 = 12;
  localparam int PWR_HD2 = 14;
  // processor flag fields
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_GIE = 4;
  // processor memory map
  localparam logic [15:0] MAP_CTRL_LO = 16'hc000;
  localparam logic [15:0] MAP_CTRL_HI = 16'hc0ff;
  localparam logic [15:0] MAP_ROM_LO = 16'he000;
  localparam logic [15:0] BOOT_VECTOR = 16'hff00;
  localparam logic [15:0] ROM_ENTRY = 16'he000;
  localparam logic [31:0] TEST_GPIO_MASK = 32'h01f8ff00;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int PLL_SETTLE_MS = 200;
  localparam int PLL_SETTLE_CYCLES = PLL_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int TESTMODE_MS = 3;
  localparam int TESTMODE_CYCLES = TESTMODE_MS * 1000 * CLK_MHZ;
  typedef enum logic [4:0] {
    ST_SETTLE = 5'b00001,
    ST_VECTOR = 5'b00010,
    ST_JUMP = 5'b00100,
    ST_RUN = 5'b01000,
    ST_SLEEP = 5'b10000
  } swrc_state_type;
endpackage

// ==== hdl/swrc_cpu_divider.sv ====
// processor step enable divider
`timescale 1ns/10ps
`default_nettype none
module swrc_cpu_divider import swrc_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // divisor minus one, tick every divisor+1 cycles
  input wire logic [W-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } swrc_div_type;
  swrc_div_type r;
  swrc_div_type n;
  // >= so a divisor lowered mid-count does not wrap the whole range
  assign tick = r.cnt >= divisor;
  always_comb begin
    n = r;
    n.cnt = tick ? '0 : r.cnt + 1'b1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // swrc_cpu_divider
`default_nettype wire

// ==== hdl/swrc_wake_detect.sv ====
// wake source qualification against the enable bits
`timescale 1ns/10ps
`default_nettype none
module swrc_wake_detect import swrc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // enables
  input wire logic [15:0] power,
  // sources
  input wire logic usb_resume_p1,
  input wire logic usb_resume_p2,
  input wire logic bus_power_pin,
  input wire logic role_id_pin,
  input wire logic host_parallel_port_read,
  input wire logic fast_serial_port_read,
  input wire logic spi_port_read,
  input wire logic external_irq_line_zero,
  // results
  output logic wake_hit,
  output logic resume_hit
);
  typedef struct packed {
    logic id_q;
    logic irq_q;
  } swrc_wake_type;
  swrc_wake_type r;
  swrc_wake_type n;
  logic id_edge;
  logic irq_edge;
  assign id_edge = r.id_q ^ role_id_pin;
  assign irq_edge = r.irq_q ^ external_irq_line_zero;
  assign resume_hit = (power[PWR_HD1] && usb_resume_p1) || (power[PWR_HD2] && usb_resume_p2);
  // each source only counts while its own enable is set
  assign wake_hit = resume_hit
    || (power[PWR_OTG] && (bus_power_pin || id_edge))
    || (power[PWR_HPI] && host_parallel_port_read)
    || (power[PWR_HSS] && fast_serial_port_read)
    || (power[PWR_SPI] && spi_port_read)
    || (power[PWR_GPI] && irq_edge);
  always_comb begin
    n = r;
    n.id_q = role_id_pin;
    n.irq_q = external_irq_line_zero;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // swrc_wake_detect
`default_nettype wire

// ==== hdl/swrc_top.sv ====
// sleep, wake and reset control with processor control registers
`timescale 1ns/10ps
`default_nettype none
module swrc_top import swrc_pkg::*; #(
  parameter int SETTLE_CYC = PLL_SETTLE_CYCLES,
  parameter int TEST_CYC = TESTMODE_CYCLES,
  // arbitrary value
  parameter logic [15:0] SILICON_VERSION = 16'h0a5c
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // processor status
  input wire logic alu_valid,
  input wire logic alu_arith,
  input wire logic alu_sub,
  input wire logic [15:0] alu_a,
  input wire logic [15:0] alu_b,
  input wire logic [15:0] alu_result,
  input wire logic global_irq_enable,
  input wire logic irq_pending,
  input wire logic [15:0] cpu_mem_addr,
  // wake sources and misc
  input wire logic usb_resume_p1,
  input wire logic usb_resume_p2,
  input wire logic bus_power_pin,
  input wire logic role_id_pin,
  input wire logic host_parallel_port_read,
  input wire logic fast_serial_port_read,
  input wire logic spi_port_read,
  input wire logic external_irq_line_zero,
  input wire logic boost_ok,
  input wire logic usb_bus_reset,
  input wire logic host_irq_ack,
  // power controls
  output logic crystal_drive_output,
  output logic pll_enable,
  output logic booster_enable,
  output logic usb_xcvr_enable,
  output logic gpio_hold,
  output logic [31:0] gpio_test_oe,
  output logic port_read_dummy,
  output logic host_port_irq_out,
  // processor side
  output logic [15:0] mem_addr_out,
  output logic ctrl_reg_sel,
  output logic rom_sel,
  output logic cpu_step,
  output logic fetch_load,
  output logic [15:0] fetch_addr,
  // register values
  output logic [15:0] working_set_base,
  output logic [3:0] core_clock_divider,
  output logic [15:0] irq_source_mask,
  output logic [15:0] debug_stop_address,
  output logic [15:0] usb_line_test,
  output logic usb_line_test_wr
);
  typedef struct packed {
    swrc_state_type st;
    logic boot;
    logic [24:0] cnt;
    logic [18:0] tcnt;
    logic ap_wr;
    logic [15:0] ap_idx;
    logic [15:0] bank, speed, power, irqen, brk, diag;
    logic diag_wr;
    logic [4:0] flags;
    logic hreadyout;
    logic [31:0] hrdata;
    logic xtal, pll, boost, xcvr, hold, step, fload, dummy, hpirq, csel, rsel;
    logic [15:0] faddr, maddr;
    logic [31:0] toe;
  } swrc_top_type;

  // pin reset lands on the power-on defaults, including a fresh boot settle
  localparam swrc_top_type RST = '{
    st: ST_SETTLE,
    boot: 1'b1,
    cnt: 25'(SETTLE_CYC - 1),
    bank: RST_BANK,
    speed: RST_SPEED,
    hreadyout: 1'b1,
    default: '0
  };

  swrc_top_type r;
  swrc_top_type n;
  logic wake_hit;
  logic resume_hit;
  logic div_tick;
  logic ap_take;
  logic map_ok;
  logic asleep;
  logic [16:0] sum;
  logic [15:0] rd;

  swrc_wake_detect u_wake (
    .clock(clock),
    .rst_n(rst_n),
    .power(r.power),
    .usb_resume_p1(usb_resume_p1),
    .usb_resume_p2(usb_resume_p2),
    .bus_power_pin(bus_power_pin),
    .role_id_pin(role_id_pin),
    .host_parallel_port_read(host_parallel_port_read),
    .fast_serial_port_read(fast_serial_port_read),
    .spi_port_read(spi_port_read),
    .external_irq_line_zero(external_irq_line_zero),
    .wake_hit(wake_hit),
    .resume_hit(resume_hit)
  );

  // only the processor step is divided; peripherals keep the full clock
  swrc_cpu_divider #(.W(4)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .divisor(r.speed[3:0]),
    .tick(div_tick)
  );

  assign ap_take = hsel && hready && htrans[1];
  assign map_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);

  always_comb begin
    n = r;
    sum = 17'h00000;
    rd = 16'h0000;
    asleep = 1'b0;
    n.fload = 1'b0;
    n.diag_wr = 1'b0;
    // ack sits before the sleep exit so a new resume wins over it
    if (host_irq_ack) begin
      n.hpirq = 1'b0;
    end
    if (r.power[PWR_HALT] && irq_pending) begin
      n.power[PWR_HALT] = 1'b0;
    end
    case (r.st)
      ST_SETTLE: begin
        if (r.cnt == 25'h0000000) begin
          n.st = r.boot ? ST_VECTOR : ST_RUN;
        end else begin
          n.cnt = r.cnt - 25'h0000001;
        end
      end
      ST_VECTOR: begin
        n.st = ST_JUMP;
        n.fload = 1'b1;
        n.faddr = BOOT_VECTOR;
      end
      ST_JUMP: begin
        n.st = ST_RUN;
        n.fload = 1'b1;
        n.faddr = ROM_ENTRY;
        n.boot = 1'b0;
        n.tcnt = 19'(TEST_CYC);
      end
      ST_RUN: begin
        if (r.tcnt != 19'h00000) begin
          n.tcnt = r.tcnt - 19'h00001;
        end
        if (r.power[PWR_SLEEP]) begin
          n.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          n.st = ST_SETTLE;
          n.cnt = 25'(SETTLE_CYC - 1);
          n.power[PWR_SLEEP] = 1'b0;
          if (resume_hit) begin
            n.hpirq = 1'b1;
          end
        end
      end
      default: begin
        n.st = ST_SETTLE;
      end
    endcase
    // bus writes land after hardware clears, so software wins a tie
    if (r.ap_wr) begin
      case (r.ap_idx)
        IDX_BANK: n.bank = hwdata[15:0] & BANK_WMASK;
        IDX_SPEED: n.speed = hwdata[15:0] & SPEED_WMASK;
        IDX_POWER: n.power = hwdata[15:0] & POWER_WMASK;
        IDX_IRQEN: n.irqen = hwdata[15:0];
        IDX_BRK: n.brk = hwdata[15:0];
        IDX_DIAG: begin
          n.diag = hwdata[15:0];
          n.diag_wr = 1'b1;
        end
        default: begin
          // flags and version are read-only; writes dropped
          n.diag_wr = 1'b0;
        end
      endcase
    end
    n.power[PWR_BOOST_OK] = boost_ok;
    // processor flags
    if (alu_sub) begin
      sum = {1'b0, alu_a} - {1'b0, alu_b};
    end else begin
      sum = {1'b0, alu_a} + {1'b0, alu_b};
    end
    n.flags[FLAG_GIE] = global_irq_enable;
    if (alu_valid) begin
      n.flags[FLAG_Z] = (alu_arith ? sum[15:0] : alu_result) == 16'h0000;
      if (alu_arith) begin
        n.flags[FLAG_N] = sum[15];
        n.flags[FLAG_C] = sum[16];
        n.flags[FLAG_V] = (alu_sub ? (alu_a[15] != alu_b[15]) : (alu_a[15] == alu_b[15]))
          && (sum[15] != alu_a[15]);
      end
    end
    // address phase; read data is taken from the next state, so a write
    // still in its data phase is already visible
    n.ap_wr = 1'b0;
    if (ap_take) begin
      n.ap_wr = hwrite && map_ok;
      n.ap_idx = haddr[17:2];
      if (!hwrite) begin
        if (map_ok) begin
          case (haddr[17:2])
            IDX_FLAGS: rd = {11'h000, n.flags};
            IDX_BANK: rd = n.bank;
            IDX_REV: rd = SILICON_VERSION;
            IDX_SPEED: rd = n.speed;
            IDX_POWER: rd = n.power;
            IDX_IRQEN: rd = n.irqen;
            IDX_BRK: rd = n.brk;
            default: rd = 16'h0000;
          endcase
        end
        n.hrdata = {16'h0000, rd};
      end
    end
    n.hreadyout = 1'b1;
    // outputs follow the next state so they line up with it
    asleep = n.st == ST_SLEEP;
    n.xtal = !asleep;
    n.pll = !asleep;
    n.boost = !asleep;
    n.xcvr = !asleep;
    n.hold = asleep;
    n.dummy = asleep;
    n.maddr = asleep ? 16'h0000 : cpu_mem_addr;
    n.csel = !asleep && (cpu_mem_addr >= MAP_CTRL_LO) && (cpu_mem_addr <= MAP_CTRL_HI);
    n.rsel = !asleep && (cpu_mem_addr >= MAP_ROM_LO);
    n.step = (n.st == ST_RUN) && !n.power[PWR_HALT] && div_tick;
    n.toe = ((n.st == ST_RUN) && (n.tcnt != 19'h00000)) ? TEST_GPIO_MASK : 32'h00000000;
  end

  // usb bus reset drives nothing here: no register of this block resets on it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign crystal_drive_output = r.xtal;
  assign pll_enable = r.pll;
  assign booster_enable = r.boost;
  assign usb_xcvr_enable = r.xcvr;
  assign gpio_hold = r.hold;
  assign gpio_test_oe = r.toe;
  assign port_read_dummy = r.dummy;
  assign host_port_irq_out = r.hpirq;
  assign mem_addr_out = r.maddr;
  assign ctrl_reg_sel = r.csel;
  assign rom_sel = r.rsel;
  assign cpu_step = r.step;
  assign fetch_load = r.fload;
  assign fetch_addr = r.faddr;
  assign working_set_base = r.bank;
  assign core_clock_divider = r.speed[3:0];
  assign irq_source_mask = r.irqen;
  assign debug_stop_address = r.brk;
  assign usb_line_test = r.diag;
  assign usb_line_test_wr = r.diag_wr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_boot_fetch;
    fetch_load && (fetch_addr == BOOT_VECTOR) ##1 fetch_load && (fetch_addr == ROM_ENTRY);
  endsequence
  sequence s_test_window;
    (gpio_test_oe == TEST_GPIO_MASK) && (r.st == ST_RUN);
  endsequence

  property p_sleep_entry;
    (r.st == ST_RUN && r.power[PWR_SLEEP]) |=> (r.st == ST_SLEEP) && gpio_hold;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_addr_low;
    gpio_hold |-> (mem_addr_out == 16'h0000) && port_read_dummy && !rom_sel;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address not low asleep");
  property p_power_off;
    (r.st == ST_SLEEP) |-> !(crystal_drive_output || pll_enable || booster_enable || usb_xcvr_enable);
  endproperty
  a_power_off: assert property (p_power_off) else $error("power left on asleep");
  property p_stall;
    (r.st == ST_SLEEP || r.st == ST_SETTLE) |-> !cpu_step;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu stepped while stalled");
  property p_wake;
    (r.st == ST_SLEEP && wake_hit) |=> (r.st == ST_SETTLE) && pll_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_ignore;
    (r.st == ST_SLEEP && !wake_hit) |=> (r.st == ST_SLEEP);
  endproperty
  a_ignore: assert property (p_ignore) else $error("woke without source");
  property p_resume_irq;
    (r.st == ST_SLEEP && resume_hit) |=> host_port_irq_out;
  endproperty
  a_resume_irq: assert property (p_resume_irq) else $error("resume irq missing");
  property p_settle_end;
    (r.st == ST_SETTLE && !r.boot && r.cnt == 25'h0000000) |=> (r.st == ST_RUN);
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("no resume after settle");
  property p_boot;
    (r.st == ST_SETTLE && r.boot && r.cnt == 25'h0000000) |=> ##1 s_boot_fetch ##1 s_test_window;
  endproperty
  a_boot: assert property (p_boot) else $error("boot fetch order wrong");
  property p_zero_flag;
    (alu_valid && !alu_arith) |=> r.flags[FLAG_Z] == ($past(alu_result) == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
  property p_flag_hold;
    !(alu_valid && alu_arith) |=> $stable(r.flags[FLAG_N:FLAG_C]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flags moved");
  property p_usb_keep;
    (usb_bus_reset && !r.ap_wr) |=> $stable(working_set_base) && $stable(irq_source_mask);
  endproperty
  a_usb_keep: assert property (p_usb_keep) else $error("usb reset hit register");
  property p_gie;
    global_irq_enable |=> r.flags[FLAG_GIE];
  endproperty
  a_gie: assert property (p_gie) else $error("gie flag wrong");
endmodule // swrc_top
`default_nettype wire

// ==== verification/swrc_wake_src.sv ====
// far-side model: wake event sources and the external port reader
`timescale 1ns/10ps
`default_nettype none
module swrc_wake_src (
  // clock
  input wire logic clock,
  // resume p2, resume p1, bus power, role id, hpi, hss and spi reads, external_irq_line_zero
  output var logic [7:0] src
);
  initial src = 8'h00;
  // a one-cycle excursion: strobes and levels give one event, edge pins give two edges
  task automatic fire(input int k);
    src[k] <= ~src[k];
    @(posedge clock);
    // a port read here only wakes the part, the reader drops what comes back
    src[k] <= ~src[k];
  endtask
endmodule // swrc_wake_src
`default_nettype wire

// ==== verification/swrc_top_tb.sv ====
// self-checking bench for the sleep, wake and reset block
`timescale 1ns/10ps
`default_nettype none
module swrc_top_tb import swrc_pkg::*;;
  localparam int SC = 20;
  localparam int TC = 10;
  // arbitrary value
  localparam logic [15:0] VER = 16'h3c5a;
  localparam logic [15:0] RIDX [4] = '{IDX_BANK, IDX_SPEED, IDX_IRQEN, IDX_BRK};
  localparam logic [15:0] RMSK [4] = '{BANK_WMASK, SPEED_WMASK, 16'hffff, 16'hffff};
  // wake enable of each partner source, in the partner's bit order
  localparam logic [15:0] EN [8] = '{16'h4000, 16'h1000, 16'h0800, 16'h0800,
    16'h0080, 16'h0200, 16'h0100, 16'h0010};
  localparam logic [15:0] MAPA [8] = '{16'hc000, 16'hc0ff, 16'hc100, 16'hbfff,
    16'he000, 16'hdfff, 16'hffff, 16'h0000};
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic alu_valid = 1'b0, alu_arith = 1'b0, alu_sub = 1'b0, gie = 1'b0;
  logic [15:0] alu_a = 16'h0, alu_b = 16'h0, alu_result = 16'h0, cpu_addr = 16'h0;
  logic bus_rst = 1'b0, irq_ack = 1'b0, rd_phase = 1'b0, irq_pend = 1'b0;
  logic hreadyout, hresp, host_irq, ctrl_sel, rom_sel, cpu_step, fetch_load;
  logic [31:0] hrdata, test_oe;
  logic [15:0] mem_addr, fetch_addr, diag;
  logic [15:0] wsb, isr, dsa;
  logic [3:0] ccd;
  logic ltw;
  wire logic [5:0] pw;
  wire logic [7:0] src;
  logic [32:0] exp_q [$];
  int errors = 0;
  int checks = 0;

  swrc_top #(.SETTLE_CYC(SC), .TEST_CYC(TC), .SILICON_VERSION(VER)) swrc_top_inst (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alu_valid(alu_valid),
    .alu_arith(alu_arith), .alu_sub(alu_sub), .alu_a(alu_a), .alu_b(alu_b),
    .alu_result(alu_result), .global_irq_enable(gie), .irq_pending(irq_pend),
    .cpu_mem_addr(cpu_addr), .usb_resume_p2(src[0]), .usb_resume_p1(src[1]),
    .bus_power_pin(src[2]), .role_id_pin(src[3]), .host_parallel_port_read(src[4]),
    .fast_serial_port_read(src[5]), .spi_port_read(src[6]),
    .external_irq_line_zero(src[7]), .boost_ok(1'b1), .usb_bus_reset(bus_rst),
    .host_irq_ack(irq_ack), .crystal_drive_output(pw[5]), .pll_enable(pw[4]),
    .booster_enable(pw[3]), .usb_xcvr_enable(pw[2]), .gpio_hold(pw[1]),
    .gpio_test_oe(test_oe), .port_read_dummy(pw[0]), .host_port_irq_out(host_irq),
    .mem_addr_out(mem_addr), .ctrl_reg_sel(ctrl_sel), .rom_sel(rom_sel),
    .cpu_step(cpu_step), .fetch_load(fetch_load), .fetch_addr(fetch_addr),
    .working_set_base(wsb), .core_clock_divider(ccd), .irq_source_mask(isr),
    .debug_stop_address(dsa), .usb_line_test(diag), .usb_line_test_wr(ltw));
  swrc_wake_src swrc_wake_src_inst (.clock(clock), .src(src));

  always #5 clock = ~clock;

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: read got %h want %h", $time, got, exp);
    end
  endtask

  // read data and response are taken at the edge that closes the data phase
  always @(posedge clock) begin
    if (rd_phase)
      chk_rd({hresp, hrdata}, exp_q.pop_front());
  end

  function automatic logic sig(input int k);
    case (k)
      0: return pw[4];
      1: return cpu_step;
      2: return fetch_load;
      default: return |test_oe;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("unexpected at %0t: wait %0d ran out", $time, k);
      stop_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
      input logic [15:0] exp);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'b00};
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
        errors++;
        $display("unexpected at %0t: bus hung", $time);
        stop_test();
      end
      if (p == 0) begin
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {16'h0, wd};
        rd_phase <= !wr;
        if (!wr)
          exp_q.push_back({17'h0, exp});
      end
    end
    rd_phase <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  task automatic boot();
    int n;
    wait_sig(2, 1'b1, SC + 10, n);
    chk_pin(n >= SC - 2 && n <= SC + 3, 1'b1, "boot delay");
    chk_pin(fetch_addr, BOOT_VECTOR, "boot vector");
    @(posedge clock);
    chk_pin({fetch_load, fetch_addr}, {1'b1, ROM_ENTRY}, "rom entry");
    wait_sig(3, 1'b1, 4, n);
    chk_pin(test_oe, TEST_GPIO_MASK, "test outputs");
    wait_sig(3, 1'b0, TC + 4, n);
    chk_pin(n > 0 && n <= TC, 1'b1, "test window");
  endtask

  task automatic defaults();
    bus(1'b0, IDX_FLAGS, 16'h0, 16'h0000);
    bus(1'b0, IDX_BANK, 16'h0, RST_BANK);
    bus(1'b0, IDX_REV, 16'h0, VER);
    bus(1'b0, IDX_SPEED, 16'h0, RST_SPEED);
    bus(1'b0, IDX_POWER, 16'h0, 16'h0004);
    bus(1'b0, IDX_IRQEN, 16'h0, 16'h0000);
    bus(1'b0, IDX_BRK, 16'h0, 16'h0000);
    bus(1'b0, IDX_DIAG, 16'h0, 16'h0000);
    bus(1'b0, 16'hc006, 16'h0, 16'h0000);
  endtask

  initial begin
    logic [15:0] w [4];
    logic [15:0] a, b, res;
    logic [16:0] r;
    logic [4:0] fl;
    logic ar, sb;
    int n;
    void'($urandom(8689));
    do_reset();
    boot();
    defaults();
    $display("test reset done");
    foreach (RIDX[i]) begin
      w[i] = 16'($urandom);
      bus(1'b1, RIDX[i], w[i], 16'h0);
      bus(1'b0, RIDX[i], 16'h0, w[i] & RMSK[i]);
    end
    chk_pin({wsb, isr}, {w[0] & RMSK[0], w[2]}, "bank and mask outputs");
    chk_pin({dsa, ccd}, {w[3], w[1][3:0]}, "stop and speed outputs");
    bus(1'b1, IDX_REV, 16'hffff, 16'h0);
    bus(1'b1, 16'hc006, 16'hffff, 16'h0);
    bus(1'b1, IDX_DIAG, w[0], 16'h0);
    @(posedge clock);
    chk_pin({ltw, diag}, {1'b1, w[0]}, "diag");
    bus_rst <= 1'b1;
    @(posedge clock);
    bus_rst <= 1'b0;
    foreach (RIDX[i])
      bus(1'b0, RIDX[i], 16'h0, w[i] & RMSK[i]);
    bus(1'b0, IDX_REV, 16'h0, VER);
    bus(1'b0, 16'hc006, 16'h0, 16'h0);
    $display("test registers done");
    bus(1'b1, IDX_SPEED, 16'h0003, 16'h0);
    wait_sig(1, 1'b1, 40, n);
    @(posedge clock);
    wait_sig(1, 1'b1, 40, n);
    chk_pin(n, 3, "step period");
    foreach (MAPA[i]) begin
      cpu_addr <= MAPA[i];
      repeat (2) @(posedge clock);
      chk_pin({ctrl_sel, rom_sel, mem_addr},
        {MAPA[i][15:8] == 8'hc0, MAPA[i] >= MAP_ROM_LO, MAPA[i]}, "map");
    end
    $display("test speed and map done");
    fl = 5'h00;
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      b = (i == 0) ? a : 16'($urandom);
      res = (i == 7) ? 16'h0 : 16'($urandom);
      ar = (i < 6);
      sb = (i == 0) || (i % 2 == 1);
      r = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      fl[4] = 1'($urandom);
      if (ar)
        fl[3:1] = {r[15], (sb ? a[15] != b[15] : a[15] == b[15]) && r[15] != a[15], r[16]};
      fl[0] = ar ? r[15:0] == 16'h0 : res == 16'h0;
      alu_valid <= 1'b1;
      alu_arith <= ar;
      alu_sub <= sb;
      alu_a <= a;
      alu_b <= b;
      alu_result <= res;
      gie <= fl[4];
      @(posedge clock);
      alu_valid <= 1'b0;
      @(posedge clock);
      bus(1'b0, IDX_FLAGS, 16'h0, {11'h0, fl});
    end
    bus(1'b1, IDX_FLAGS, 16'hffff, 16'h0);
    bus(1'b0, IDX_FLAGS, 16'h0, {11'h0, fl});
    gie <= 1'b0;
    $display("test flags done");
    bus(1'b1, IDX_SPEED, 16'h0000, 16'h0);
    bus(1'b1, IDX_POWER, 16'h0001, 16'h0);
    repeat (2) @(posedge clock);
    chk_pin(cpu_step, 1'b0, "halted");
    irq_pend <= 1'b1;
    @(posedge clock);
    irq_pend <= 1'b0;
    wait_sig(1, 1'b1, 4, n);
    bus(1'b0, IDX_POWER, 16'h0, 16'h0004);
    for (int i = 0; i < 8; i++) begin
      cpu_addr <= 16'($urandom) | 16'h0001;
      // charge pump taken as already off by firmware
      bus(1'b1, IDX_POWER, EN[i] | 16'h0002, 16'h0);
      wait_sig(0, 1'b0, 6, n);
      repeat (2) @(posedge clock);
      chk_pin({pw, mem_addr, cpu_step}, {6'b000011, 17'h0}, "asleep");
      swrc_wake_src_inst.fire((i + 2) % 8);
      repeat (4) @(posedge clock);
      chk_pin(pw[4], 1'b0, "disabled source");
      swrc_wake_src_inst.fire(i);
      wait_sig(0, 1'b1, 6, n);
      chk_pin(host_irq, i < 2, "resume irq");
      wait_sig(1, 1'b1, SC + 10, n);
      chk_pin(n >= SC - 2 && n <= SC + 6, 1'b1, "settle");
      bus(1'b0, IDX_POWER, 16'h0, EN[i] | 16'h0004);
      irq_ack <= 1'b1;
      @(posedge clock);
      irq_ack <= 1'b0;
      repeat (2) @(posedge clock);
      chk_pin(host_irq, 1'b0, "irq cleared");
    end
    $display("test sleep done");
    do_reset();
    boot();
    defaults();
    $display("test pin reset done");
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("unexpected at %0t: run too long", $time);
    stop_test();
  end
endmodule // swrc_top_tb
`default_nettype wire
